/* hdl/mode_seq_pkg.sv */
// Overview of operation
// - start in power-up state after power applied
// - antenna deployed: power-up goes to transponder
// - antenna not deployed: power-up goes startup
// - startup waits 45 min, deploys, then transponder
// - red led flashes during startup wait
// - 1 kHz intermittent beep during startup wait
// - transponder mode: transponder and low-rate telemetry
// - data mode: high-rate telemetry, transponder off
// - data mode ends after 24 h, renewable
// - uplink commands accepted in every mode except power-up
// - data-mode command enters data mode
`default_nettype none
package mode_seq_pkg;
    // ==========================================
    // timing
    localparam int unsigned CLK_HZ          = 10_000_000;  // core clock rate
    localparam int unsigned TONE_HZ         = 1000;        // beep pitch
    localparam int unsigned TICK_HZ         = 1;           // interval tick rate
    localparam int unsigned STARTUP_MIN     = 45;          // startup wait, minutes
    localparam int unsigned DATA_HOURS      = 24;          // data mode hold, hours
    localparam int unsigned STARTUP_TICKS   = STARTUP_MIN * 60 * TICK_HZ;
    localparam int unsigned DATA_TICKS      = DATA_HOURS * 3600 * TICK_HZ;
    localparam int unsigned TICK_DIV        = CLK_HZ / TICK_HZ;
    // toggle twice per tone period
    localparam int unsigned TONE_DIV        = CLK_HZ / (2 * TONE_HZ);
    localparam int unsigned CNT_W           = 32;          // interval counter width
    localparam int unsigned DIV_W           = 24;          // divider counter width
    // ==========================================
    // operating modes
    typedef enum logic [4:0] {
        ST_POWERUP = 5'h01,
        ST_STARTUP = 5'h02,
        ST_DEPLOY  = 5'h04,
        ST_XPDR    = 5'h08,
        ST_DATA    = 5'h10
    } mode_t;
endpackage : mode_seq_pkg
`default_nettype wire

/* hdl/rate_divider.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// free running divider giving one-cycle enables
module rate_divider
    import mode_seq_pkg::*;
#(
    parameter int unsigned DIV = 10
)(
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // divided enable pulse
    output logic      pulse
);
    logic [DIV_W-1:0] cnt_q;  // cycle count within period

    // wrap at DIV-1, pulse on wrap
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            cnt_q <= '0;
        else if (cnt_q == DIV_W'(DIV - 1))
            cnt_q <= '0;
        else
            cnt_q <= cnt_q + 1'b1;
    end

    assign pulse = (cnt_q == DIV_W'(DIV - 1));
endmodule : rate_divider
`default_nettype wire

/* hdl/satellite_mode_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// operating mode sequencer for the housekeeping unit
module satellite_mode_sequencer
    import mode_seq_pkg::*;
#(
    parameter int unsigned STARTUP_T = STARTUP_TICKS,  // startup wait in ticks
    parameter int unsigned DATA_T    = DATA_TICKS,     // data hold in ticks
    parameter int unsigned TICK_D    = TICK_DIV,       // clocks per tick
    parameter int unsigned TONE_D    = TONE_DIV        // clocks per tone half
)(
    // clock and reset
    input  wire logic CORE_CLK,
    input  wire logic RST,
    // antenna and uplink
    input  wire logic ANT_DEPLOYED,
    input  wire logic DATA_CMD,
    input  wire logic XPDR_CMD,
    // antenna release
    output logic      ANT_DEPLOY,
    // radio enables
    output logic      XPDR_EN,
    output logic      LOW_TLM_EN,
    output logic      HIGH_TLM_EN,
    // startup indicators
    output logic      RED_LED,
    output logic      BEEPER,
    // mode report
    output mode_t     MODE
);
    // ==========================================
    // divided enables
    logic tick;      // interval tick
    logic tone_en;   // tone half-period enable

    rate_divider #(.DIV(TICK_D)) u_tick
    (
        .clk   (CORE_CLK),
        .rst   (RST),
        .pulse (tick)
    );

    rate_divider #(.DIV(TONE_D)) u_tone
    (
        .clk   (CORE_CLK),
        .rst   (RST),
        .pulse (tone_en)
    );

    // ==========================================
    // mode state
    mode_t            st_q;    // current mode
    mode_t            st_d;    // next mode
    logic [CNT_W-1:0] cnt_q;   // interval count in ticks
    logic             done_su; // startup wait elapsed
    logic             done_dm; // data hold elapsed

    assign done_su = tick && (cnt_q >= CNT_W'(STARTUP_T - 1));
    assign done_dm = tick && (cnt_q >= CNT_W'(DATA_T - 1));

    // next mode; uplink checked in every mode after power-up
    always_comb
    begin
        st_d = st_q;
        case (st_q)
            ST_POWERUP: st_d = ANT_DEPLOYED ? ST_XPDR : ST_STARTUP;
            ST_STARTUP: if (done_su) st_d = ST_DEPLOY;
            ST_DEPLOY:  st_d = ST_XPDR;
            ST_DATA:    if (done_dm) st_d = ST_XPDR;
            ST_XPDR:    st_d = ST_XPDR;
            default:    st_d = ST_POWERUP;
        endcase
        if (st_q != ST_POWERUP)
        begin
            if (DATA_CMD)
                st_d = ST_DATA;
            else if (XPDR_CMD)
                st_d = ST_XPDR;
        end
    end

    always_ff @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
            st_q <= ST_POWERUP;
        else
            st_q <= st_d;
    end

    // interval counter; restarts on any mode entry or data renewal
    always_ff @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
            cnt_q <= '0;
        else if (st_d != st_q || (st_q == ST_DATA && DATA_CMD))
            cnt_q <= '0;
        else if (tick)
            cnt_q <= cnt_q + 1'b1;
    end

    // ==========================================
    // indicators: led flashes at tick, beep gated at tick rate
    logic tone_q;   // 1 kHz square wave
    logic blink_q;  // flash and beep cadence

    always_ff @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
            tone_q <= 1'b0;
        else if (tone_en)
            tone_q <= ~tone_q;
    end

    always_ff @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
            blink_q <= 1'b0;
        else if (st_q != ST_STARTUP)
            blink_q <= 1'b0;
        else if (tick)
            blink_q <= ~blink_q;
    end

    // ==========================================
    // registered outputs
    always_ff @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
        begin
            ANT_DEPLOY  <= 1'b0;
            XPDR_EN     <= 1'b0;
            LOW_TLM_EN  <= 1'b0;
            HIGH_TLM_EN <= 1'b0;
            RED_LED     <= 1'b0;
            BEEPER      <= 1'b0;
            MODE        <= ST_POWERUP;
        end
        else
        begin
            ANT_DEPLOY  <= (st_d == ST_DEPLOY);
            XPDR_EN     <= (st_d == ST_XPDR);
            LOW_TLM_EN  <= (st_d == ST_XPDR);
            HIGH_TLM_EN <= (st_d == ST_DATA);
            RED_LED     <= (st_q == ST_STARTUP) && blink_q;
            BEEPER      <= (st_q == ST_STARTUP) && blink_q && tone_q;
            MODE        <= st_d;
        end
    end

    // ==========================================
    // checks
    a_powerup_deployed: assert property (@(posedge CORE_CLK) disable iff (RST)
        (st_q == ST_POWERUP && ANT_DEPLOYED) |=> st_q == ST_XPDR)
        else $error("deployed antennas did not lead to transponder");
    a_powerup_stowed: assert property (@(posedge CORE_CLK) disable iff (RST)
        (st_q == ST_POWERUP && !ANT_DEPLOYED) |=> st_q == ST_STARTUP)
        else $error("stowed antennas did not lead to startup");
    sequence s_deploy;
        ANT_DEPLOY ##1 (XPDR_EN || HIGH_TLM_EN);
    endsequence
    a_deploy_then_xpdr: assert property (@(posedge CORE_CLK) disable iff (RST)
        (st_q == ST_DEPLOY && !DATA_CMD && !XPDR_CMD) |-> s_deploy)
        else $error("deploy not followed by transponder mode");
    a_led_only_startup: assert property (@(posedge CORE_CLK) disable iff (RST)
        RED_LED |-> $past(st_q) == ST_STARTUP)
        else $error("led lit outside startup");
    a_beep_gated: assert property (@(posedge CORE_CLK) disable iff (RST)
        BEEPER |-> RED_LED)
        else $error("beep outside flash phase");
    a_xpdr_outputs: assert property (@(posedge CORE_CLK) disable iff (RST)
        (MODE == ST_XPDR) |-> (XPDR_EN && LOW_TLM_EN && !HIGH_TLM_EN))
        else $error("transponder mode enables wrong");
    a_data_outputs: assert property (@(posedge CORE_CLK) disable iff (RST)
        (MODE == ST_DATA) |-> (HIGH_TLM_EN && !XPDR_EN))
        else $error("data mode enables wrong");
    a_data_cmd_taken: assert property (@(posedge CORE_CLK) disable iff (RST)
        (st_q != ST_POWERUP && DATA_CMD) |=> (st_q == ST_DATA && cnt_q == '0))
        else $error("data command not acted on");
    a_reset_state: assert property (@(posedge CORE_CLK)
        $fell(RST) |-> st_q == ST_POWERUP)
        else $error("reset did not restore power-up");
endmodule : satellite_mode_sequencer
`default_nettype wire

/* verification/uplink_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// uplink decoder and antenna hardware stand-in
module uplink_model
(
    // clock
    input  wire logic clk,
    // release pulse from the sequencer
    input  wire logic ant_deploy,
    // command pulses and antenna state
    output var logic  data_cmd,
    output var logic  xpdr_cmd,
    output var logic  ant_deployed
);
    // idle until the bench asks
    initial
    begin
        data_cmd     = 1'b0;
        xpdr_cmd     = 1'b0;
        ant_deployed = 1'b0;
    end
    always @(posedge clk)
    begin
        if (ant_deploy)
            ant_deployed <= 1'b1;
    end
    task send_cmd(input logic d, input logic x);
        @(posedge clk);
        data_cmd <= d;
        xpdr_cmd <= x;
        @(posedge clk);
        data_cmd <= 1'b0;
        xpdr_cmd <= 1'b0;
    endtask : send_cmd
    // preset antenna state before a reset
    task set_ant(input logic v);
        @(posedge clk);
        ant_deployed <= v;
    endtask : set_ant
endmodule : uplink_model
`default_nettype wire

/* verification/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// bench for the mode sequencer
module tb_top;
    import mode_seq_pkg::*;
    typedef struct packed {logic ant; mode_t m; logic [2:0] en;} row_t;
    logic  clk, rst, adep, aok, dcmd, xcmd, xen, lo, hi, red, bp, pr, pb;
    mode_t mode;
    int    err_count, compares, n, tg, bt;
    // short counts keep the run brief
    row_t  rows [2] = '{'{1'b1, ST_XPDR, 3'b110}, '{1'b0, ST_STARTUP, 3'b000}};
    satellite_mode_sequencer #(.STARTUP_T(3), .DATA_T(5), .TICK_D(10), .TONE_D(2))
        i_satellite_mode_sequencer (.CORE_CLK(clk), .RST(rst), .ANT_DEPLOYED(aok),
        .DATA_CMD(dcmd), .XPDR_CMD(xcmd), .ANT_DEPLOY(adep), .XPDR_EN(xen),
        .LOW_TLM_EN(lo), .HIGH_TLM_EN(hi), .RED_LED(red), .BEEPER(bp), .MODE(mode));
    uplink_model i_uplink_model (.clk(clk), .ant_deploy(adep), .data_cmd(dcmd),
        .xpdr_cmd(xcmd), .ant_deployed(aok));
    // 100 ns clock
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp)
        begin
            err_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task print_verdict;
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : print_verdict
    // reset with given antenna state, sampled on falling edges
    task do_reset(input logic a);
        i_uplink_model.set_ant(a);
        rst <= 1'b1;
        repeat (10) @(posedge clk);
        @(negedge clk);
        check(mode, ST_POWERUP);
        check({xen, lo, hi, adep}, 8'h00);
        @(posedge clk);
        rst <= 1'b0;
        // the release edge itself still shows power-up
        @(negedge clk);
        check(mode, ST_POWERUP);
        // first edge after release leaves power-up
        @(negedge clk);
    endtask : do_reset
    task cmd(input logic d, input logic x);
        i_uplink_model.send_cmd(d, x);
        @(negedge clk);
    endtask : cmd
    // ==========================================
    // main sequence
    initial
    begin
        rst = 1'b1;
        err_count = 0;
        compares = 0;
        // a stuck mode leaves this block early, straight to the verdict
        begin : body
        foreach (rows[i])
        begin
            do_reset(rows[i].ant);
            check(mode, rows[i].m);
            check({xen, lo, hi}, rows[i].en);
            $display("row %0d done", i);
        end
        // startup wait with flashing and beeping
        n = 0; tg = 0; bt = 0; pr = red; pb = bp;
        while (mode === ST_STARTUP && n < 200)
        begin
            @(negedge clk);
            n++;
            tg += (red !== pr);
            bt += (bp !== pb);
            pr = red;
            pb = bp;
        end
        check(n >= 20 && n <= 32, 1'b1);
        if (n >= 200)
            disable body;
        check(tg >= 2, 1'b1);
        check(bt >= 4, 1'b1);
        check({mode, adep}, {ST_DEPLOY, 1'b1});
        @(negedge clk);
        check({mode, adep, xen, lo}, {ST_XPDR, 3'b011});
        $display("startup done");
        // data mode, renewed, then timed return
        cmd(1'b1, 1'b0);
        check(mode, ST_DATA);
        check({xen, lo, hi}, 3'b001);
        repeat (30) @(posedge clk);
        cmd(1'b1, 1'b0);
        n = 0;
        while (mode !== ST_XPDR && n < 100)
        begin
            @(negedge clk);
            n++;
        end
        check(n >= 38 && n <= 52, 1'b1);
        if (n >= 100)
            disable body;
        // back to back commands, transponder command wins last
        cmd(1'b1, 1'b0);
        check(mode, ST_DATA);
        cmd(1'b0, 1'b1);
        check(mode, ST_XPDR);
        // both commands in one cycle: data mode has priority
        cmd(1'b1, 1'b1);
        check(mode, ST_DATA);
        $display("data mode done");
        // command aborts startup, then reset re-checks antennas
        do_reset(1'b0);
        cmd(1'b1, 1'b0);
        check(mode, ST_DATA);
        do_reset(1'b1);
        check(mode, ST_XPDR);
        $display("awkward cases done");
        end
        print_verdict();
    end
endmodule : tb_top
`default_nettype wire
